// ===== core/sps_pkg.sv
// Package for the stepper phase sequencer: constants and carrier types.
// Assumes a 125 MHz system clock and a 16-microstep-per-quarter table.
package sps_pkg;

	// Phase index covers one electrical cycle in sixteenth steps
	localparam int unsigned IDX_W       = 6;
	localparam logic [5:0]  IDX_RESET   = 6'h00;
	localparam logic [5:0]  STEP_FULL   = 6'h10; // Full step, two-phase
	localparam logic [5:0]  STEP_HALF   = 6'h08;
	localparam logic [5:0]  STEP_QUART  = 6'h04;
	localparam logic [5:0]  STEP_EIGHTH = 6'h02;
	localparam logic [5:0]  STEP_SIXT   = 6'h01;
	// Full step sits between coils, so the drive reads the table half a step past the index
	localparam logic [5:0]  FULL_OFFSET = 6'h08;

	// Table amplitude width
	localparam int unsigned AMP_W = 8;

	// Host-supplied mode and motion levels
	typedef struct packed {
		logic step_size_hi_bit;
		logic step_size_lo_bit;
		logic edge_select_bit;
		logic rotation_direction;
	} sps_mode_s;

	// Drive to the four phase switches and their current references
	typedef struct packed {
		logic [3:0]       phase_on;  // A, A-bar, B, B-bar
		logic [AMP_W-1:0] amp_a;
		logic [AMP_W-1:0] amp_b;
	} sps_drive_s;

	// Whole state of the sequencer
	typedef struct packed {
		logic [1:0]       clk_sync;
		logic [1:0]       en_sync;
		logic [1:0]       rst_sync;
		logic             clk_prev;
		sps_mode_s [1:0]  mode_sync; // Mode and direction synchroniser
		logic [IDX_W-1:0] index;
		sps_drive_s       drive;
	} sps_state_s;

endpackage : sps_pkg

// ===== core/sps_sequencer.sv
// Step sequencer of a unipolar two-phase stepping motor driver.
// Assumes step, direction, mode, enable and reset come from pins,
// asynchronous to clock_i; mode and direction are held stable near edges.
// Every pin passes two flops; an index step lands three edges after the
// pin edge and the coil drive follows one edge later.
// Functional notes
// - Edge select high: rising edges only; modes full, half, quarter, eighth.
// - Edge select low: both edges; modes half, quarter, eighth, sixteenth.
// - Direction low steps forward, high steps reverse.
// - Enable low switches off every phase drive.
// - Active-low reset pin holds the sequencer in its reset state.
// - Enable low freezes phase state and ignores all inputs except reset.
`timescale 1ns/1ps

module sps_sequencer (
	input  wire logic               clock_i,
	input  wire logic               sys_rst_i,
	input  wire logic               step_clk_i,
	input  wire logic               rotation_direction_i,
	input  wire logic               step_size_sel_lo_i,
	input  wire logic               step_size_sel_hi_i,
	input  wire logic               edge_select_i,
	input  wire logic               enable_i,
	input  wire logic               reset_n_i,
	output logic [3:0]              phase_on_o,
	output logic [sps_pkg::AMP_W-1:0] amp_a_o,
	output logic [sps_pkg::AMP_W-1:0] amp_b_o,
	output logic [sps_pkg::IDX_W-1:0] phase_index_o
);

	// Whole state, its next value and the carriers built from it
	sps_pkg::sps_state_s state_reg;
	sps_pkg::sps_state_s state_next;
	sps_pkg::sps_mode_s  mode_pin;
	sps_pkg::sps_mode_s  mode;
	sps_pkg::sps_drive_s drive_calc;

	logic                       step_lvl;
	logic                       en_lvl;
	logic                       rst_lvl;
	logic                       edge_hit;
	logic [sps_pkg::IDX_W-1:0]  step_amt;
	logic [sps_pkg::IDX_W-1:0]  idx_moved;
	logic                       full_mode;
	logic [sps_pkg::IDX_W-1:0]  drive_idx;

	////////////////////////////////////////////////////////////////////////
	// Quarter-wave sine magnitude, sixteen steps per quarter
	// Argument 16 lands on the default: full current on that coil
	function automatic logic [7:0] sps_sine(input logic [4:0] q);
		logic [7:0] v;
		v = 8'h00;
		case (q)
			5'd0:    v = 8'h00;
			5'd1:    v = 8'h19;
			5'd2:    v = 8'h31;
			5'd3:    v = 8'h4a;
			5'd4:    v = 8'h61;
			5'd5:    v = 8'h78;
			5'd6:    v = 8'h8e;
			5'd7:    v = 8'ha2;
			5'd8:    v = 8'hb5;
			5'd9:    v = 8'hc7;
			5'd10:   v = 8'hd5;
			5'd11:   v = 8'he2;
			5'd12:   v = 8'hed;
			5'd13:   v = 8'hf5;
			5'd14:   v = 8'hfb;
			5'd15:   v = 8'hfe;
			default: v = 8'hff;
		endcase
		return v;
	endfunction : sps_sine

	////////////////////////////////////////////////////////////////////////
	// Synchronised levels: second stage only, the first stage is never
	// read so a metastable first flop cannot reach the logic
	assign step_lvl = state_reg.clk_sync[1];
	assign en_lvl   = state_reg.en_sync[1];
	assign rst_lvl  = state_reg.rst_sync[1];

	// Raw mode and direction levels, gathered for the synchroniser
	assign mode_pin.step_size_hi_bit   = step_size_sel_hi_i;
	assign mode_pin.step_size_lo_bit   = step_size_sel_lo_i;
	assign mode_pin.edge_select_bit    = edge_select_i;
	assign mode_pin.rotation_direction = rotation_direction_i;

	// Mode after two flops, in step with the synced step level; the host
	// keeps these pins steady around edges, so the bits cannot skew
	assign mode = state_reg.mode_sync[1];

	// Active edge detection per edge select: rising-only compares the
	// synced level with the last one, both-edge mode takes any difference
	always_comb begin
		if (mode.edge_select_bit) begin
			edge_hit = step_lvl & ~state_reg.clk_prev;
		end else begin
			edge_hit = step_lvl ^ state_reg.clk_prev;
		end
	end

	// Step size from the mode pins and edge select
	// Sizes count sixteenth steps, one table cycle is 64 index units
	always_comb begin
		case ({mode.edge_select_bit, mode.step_size_hi_bit,
			mode.step_size_lo_bit})
			3'b100:  step_amt = sps_pkg::STEP_FULL;
			3'b101:  step_amt = sps_pkg::STEP_HALF;
			3'b110:  step_amt = sps_pkg::STEP_QUART;
			3'b111:  step_amt = sps_pkg::STEP_EIGHTH;
			3'b000:  step_amt = sps_pkg::STEP_HALF;
			3'b001:  step_amt = sps_pkg::STEP_QUART;
			3'b010:  step_amt = sps_pkg::STEP_EIGHTH;
			3'b011:  step_amt = sps_pkg::STEP_SIXT;
			default: step_amt = sps_pkg::STEP_HALF;
		endcase
	end

	// Wrap-around index move by direction
	// Six-bit index wraps by itself at both ends of the table
	always_comb begin
		if (mode.rotation_direction) begin
			idx_moved = state_reg.index - step_amt;
		end else begin
			idx_moved = state_reg.index + step_amt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Full-step mode energises both coils except at an index 8 past a full step: the drive reads the table
	// half a step past the index, between the two coil axes
	always_comb begin
		full_mode = mode.edge_select_bit & ~mode.step_size_hi_bit
			& ~mode.step_size_lo_bit;
		if (full_mode) begin
			drive_idx = state_reg.index + sps_pkg::FULL_OFFSET;
		end else begin
			drive_idx = state_reg.index;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Phase drive from the drive index: quadrant picks coil polarity,
	// position within it picks the two current levels
	always_comb begin
		logic [1:0] quad;
		logic [3:0] pos;
		logic [4:0] qa;
		logic [4:0] qb;
		quad = drive_idx[5:4];
		pos  = drive_idx[3:0];
		qa   = 5'd16 - {1'b0, pos};
		qb   = {1'b0, pos};
		drive_calc.amp_a = sps_sine(qa);
		drive_calc.amp_b = sps_sine(qb);
		case (quad)
			2'd0:    drive_calc.phase_on = 4'b1010;
			2'd1:    drive_calc.phase_on = 4'b0110;
			2'd2:    drive_calc.phase_on = 4'b0101;
			2'd3:    drive_calc.phase_on = 4'b1001;
			default: drive_calc.phase_on = 4'b0000;
		endcase
		// Zero amplitude switches that coil off entirely
		if (drive_calc.amp_a == 8'h00) begin
			drive_calc.phase_on[3:2] = 2'b00;
		end
		if (drive_calc.amp_b == 8'h00) begin
			drive_calc.phase_on[1:0] = 2'b00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Next state: synchronisers shift on every edge, whatever the mode
	always_comb begin
		state_next           = state_reg;
		state_next.clk_sync  = {state_reg.clk_sync[0], step_clk_i};
		state_next.en_sync   = {state_reg.en_sync[0], enable_i};
		state_next.rst_sync  = {state_reg.rst_sync[0], ~reset_n_i};
		state_next.mode_sync = {state_reg.mode_sync[0], mode_pin};
		// Edge history always follows the synced level: a step edge that
		// arrives in reset or while disabled is absorbed, never replayed
		state_next.clk_prev  = step_lvl;
		if (rst_lvl) begin
			// Reset pin wins over enable and over any pending edge
			state_next.index = sps_pkg::IDX_RESET;
			state_next.drive = '0;
		end else if (!en_lvl) begin
			// Frozen: index kept, drive off until enable returns
			state_next.drive = '0;
		end else begin
			if (edge_hit) begin
				state_next.index = idx_moved;
			end
			state_next.drive = drive_calc;
		end
	end

	// State register, synchronous reset; clears the synchronisers too, so
	// enable reads low for two edges after release and nothing moves
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// Outputs from flip-flops
	// Index leads the drive by one edge, the drive is built from it
	assign phase_on_o    = state_reg.drive.phase_on;
	assign amp_a_o       = state_reg.drive.amp_a;
	assign amp_b_o       = state_reg.drive.amp_b;
	assign phase_index_o = state_reg.index;

endmodule : sps_sequencer

// ===== testbench/sps_chk.sv
// Port checker for the phase sequencer.
// Assumes mode and direction pins are steady near step edges.
`timescale 1ns/1ps
module sps_chk (
	input wire logic       clock_i,
	input wire logic       sys_rst_i,
	input wire logic       step_clk_i,
	input wire logic       rotation_direction_i,
	input wire logic       step_size_sel_lo_i,
	input wire logic       step_size_sel_hi_i,
	input wire logic       edge_select_i,
	input wire logic       enable_i,
	input wire logic       reset_n_i,
	input wire logic [3:0] phase_on_o,
	input wire logic [5:0] phase_index_o
);
	logic [5:0] stp;
	logic       live;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);
	// Step size of the selected mode
	assign stp = (edge_select_i ? 6'h10 : 6'h08) >>
		{step_size_sel_hi_i, step_size_sel_lo_i};
	assign live = enable_i && reset_n_i;
	sequence s_moved;
		##[2:4] $changed(phase_index_o);
	endsequence
	a_rise_move:
		assert property ($rose(step_clk_i) && live |-> s_moved)
		else $error("rise not taken");
	a_both_move:
		assert property ($fell(step_clk_i) && live && !edge_select_i |-> s_moved)
		else $error("fall not taken");
	a_fall_skip:
		assert property ($fell(step_clk_i) && edge_select_i
			|=> $stable(phase_index_o) [*4])
		else $error("fall taken");
	a_fwd_size:
		assert property ($changed(phase_index_o) && reset_n_i &&
			!rotation_direction_i |-> phase_index_o == $past(phase_index_o) + stp)
		else $error("bad forward step");
	a_rev_size:
		assert property ($changed(phase_index_o) && reset_n_i &&
			rotation_direction_i |-> phase_index_o == $past(phase_index_o) - stp)
		else $error("bad reverse step");
	a_rst_zero:
		assert property (!reset_n_i [*5] |-> phase_index_o == 6'h00 &&
			phase_on_o == 4'h0)
		else $error("reset not held");
	a_en_off:
		assert property (!enable_i [*5] |-> phase_on_o == 4'h0)
		else $error("drive on while disabled");
	a_en_freeze:
		assert property ((!enable_i && reset_n_i) [*5] |=> $stable(phase_index_o))
		else $error("index moved while disabled");
endmodule : sps_chk
bind sps_sequencer sps_chk u_chk (.clock_i, .sys_rst_i, .step_clk_i,
	.rotation_direction_i, .step_size_sel_lo_i, .step_size_sel_hi_i,
	.edge_select_i, .enable_i, .reset_n_i, .phase_on_o, .phase_index_o);

// ===== testbench/sps_host.sv
// Host model driving step, direction, mode, enable, reset.
// Assumes one caller; pins move 1 ns after a clock edge.
`timescale 1ns/1ps
module sps_host (
	input  wire logic clock_i,
	output logic      step_o,
	output logic      dir_o,
	output logic      lo_o,
	output logic      hi_o,
	output logic      sel_o,
	output logic      en_o,
	output logic      rst_n_o
);
	// Step level half period and mode hold, in clock cycles of 8 ns
	localparam int LVL_CYC  = 1250; // 10 us pulse, 50 kHz at most
	localparam int HOLD_CYC = 875;  // 7 us clear of each step edge
	// Power-on levels; system reset gives the power-on clear
	initial begin
		{step_o, dir_o, lo_o, hi_o, sel_o, en_o, rst_n_o} = 7'h03;
	end
	// Step level held 10 us; other pins stay put meanwhile
	task automatic lvl(input logic v);
		repeat (LVL_CYC) @(posedge clock_i);
		#1 step_o = v;
	endtask : lvl
	// Mode and direction change 7 us after the last step edge; the
	// next edge follows a full level later
	task automatic mode(input logic [3:0] v);
		repeat (HOLD_CYC) @(posedge clock_i);
		#1 {sel_o, hi_o, lo_o, dir_o} = v;
	endtask : mode
	// Enable and reset levels; the caller holds reset low for 10 us
	task automatic pins(input logic e, input logic r);
		@(posedge clock_i);
		#1 {en_o, rst_n_o} = {e, r};
	endtask : pins
endmodule : sps_host

// ===== testbench/sps_sequencer_tb.sv
// Bench: host model steps the sequencer, index checked via queue.
// Assumes the index moves a few cycles after each taken edge.
`timescale 1ns/1ps
module sps_sequencer_tb;
	logic       clock_i = 1'b0;
	logic       sys_rst_i = 1'b1;
	logic       stp, dir, lo, hi, sel, en, rst_n;
	logic [3:0] phase_on;
	logic [5:0] idx, prev, exp_idx;
	logic [7:0] amp_a, amp_b;
	logic [5:0] q[$];
	int         err_total = 0;
	int         checked = 0;
	bit         watch = 1'b0;
	initial forever #4 clock_i = ~clock_i;
	sps_host host (.clock_i, .step_o(stp), .dir_o(dir), .lo_o(lo), .hi_o(hi),
		.sel_o(sel), .en_o(en), .rst_n_o(rst_n));
	sps_sequencer uut (.clock_i, .sys_rst_i, .step_clk_i(stp),
		.rotation_direction_i(dir), .step_size_sel_lo_i(lo),
		.step_size_sel_hi_i(hi), .edge_select_i(sel), .enable_i(en),
		.reset_n_i(rst_n), .phase_on_o(phase_on), .amp_a_o(amp_a),
		.amp_b_o(amp_b),
		.phase_index_o(idx));
	task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp
	task automatic wrap_up;
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : wrap_up
	// One step level; note the index it should give
	task automatic edge_go(input logic v);
		host.lvl(v);
		if (v || !sel) begin
			exp_idx = dir ? exp_idx - ((sel ? 6'h10 : 6'h08) >> {hi, lo})
				: exp_idx + ((sel ? 6'h10 : 6'h08) >> {hi, lo});
			q.push_back(exp_idx);
		end
	endtask : edge_go
	task automatic pulse;
		edge_go(1'b1);
		edge_go(1'b0);
	endtask : pulse
	// Each index change takes the oldest note
	always @(posedge clock_i) begin
		if (watch && idx !== prev) begin
			if (q.size() == 0) cmp("spare step", 8'h00, 8'h01);
			else cmp("index", {2'b00, q.pop_front()}, {2'b00, idx});
		end
		prev <= idx;
	end
	// Main sequence
	initial begin
		void'($urandom(32'h2db6));
		exp_idx = 6'h00;
		repeat (16) @(posedge clock_i);
		#1 sys_rst_i = 1'b0;
		repeat (4) @(posedge clock_i);
		#1 cmp("reset index", 8'h00, {2'b00, idx});
		cmp("coil a full", 8'hff, amp_a);
		cmp("coil b zero", 8'h00, amp_b);
		cmp("one coil on", 8'h08, {4'h0, phase_on});
		watch = 1'b1;
		for (int m = 0; m < 8; m++) begin
			host.mode({m[2:0], 1'($urandom)});
			pulse();
			pulse();
		end
		host.mode(4'h8);
		repeat (5) pulse();
		host.pins(1'b0, 1'b1);
		host.lvl(1'b1);
		cmp("drive off", 8'h00, {4'h0, phase_on});
		host.pins(1'b1, 1'b1);
		host.lvl(1'b0);
		pulse();
		repeat (8) @(posedge clock_i);
		watch = 1'b0;
		host.pins(1'b1, 1'b0);
		repeat (1250) @(posedge clock_i);
		#1 cmp("held index", 8'h00, {2'b00, idx});
		cmp("held drive", 8'h00, {4'h0, phase_on});
		host.pins(1'b1, 1'b1);
		repeat (4) @(posedge clock_i);
		#1 cmp("two coils on", 8'h0a, {4'h0, phase_on});
		exp_idx = 6'h00;
		watch = 1'b1;
		pulse();
		repeat (8) @(posedge clock_i);
		cmp("notes left", 8'h00, 8'(q.size()));
		wrap_up();
	end
	// Watchdog, some 15 percent past the expected run of 70k cycles
	initial begin
		#640000;
		err_total++;
		wrap_up();
	end
endmodule : sps_sequencer_tb
